// [pkg/supervisor_pkg.sv]
package supervisor_pkg;

    // Serial frame layout: {command, address, data}
    localparam int          SPI_WORD_BITS   = 16;
    localparam int          SPI_CNT_BITS    = 5;
    localparam int          CMD_MSB         = 15;
    localparam int          CMD_LSB         = 12;
    localparam int          ADDR_MSB        = 11;
    localparam int          ADDR_LSB        = 8;
    localparam int          DATA_MSB        = 7;
    localparam int          ECHO_MSB        = 11;
    localparam logic [3:0]  CMD_CHECK       = 4'h0;
    localparam logic [3:0]  CMD_WRITE       = 4'h1;
    localparam logic [3:0]  CMD_READ        = 4'h2;
    localparam logic [3:0]  CHECK_ECHO_HEAD = 4'h7;

    // Register addresses
    localparam logic [3:0]  ADDR_CTRL1      = 4'h1;
    localparam logic [3:0]  ADDR_WD_CFG     = 4'h2;
    localparam logic [3:0]  ADDR_WD_CTRL    = 4'h3;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;

    // Control register 1 fields
    localparam int          CTRL1_POWER_HOLD_BIT = 0;
    localparam int          CTRL1_SELF_TEST_BIT  = 6;
    localparam int          CTRL1_SOFT_RESET_BIT = 7;
    localparam logic [7:0]  CTRL1_RESET          = 8'h00;

    // Watchdog configuration and control fields
    localparam int          WD_ENABLE_BIT     = 7;
    localparam int          WD_MULT_1S_BIT    = 6;
    localparam int          WD_MULT_100MS_BIT = 5;
    localparam int          WD_MULT_10MS_BIT  = 4;
    localparam int          WD_DIGIT_MSB      = 3;
    localparam int          WD_TEMP_MSB       = 6;
    localparam logic [7:0]  WD_CFG_RESET      = 8'hca;
    localparam logic [7:0]  WD_CTRL_RESET     = 8'h00;
    localparam logic [3:0]  WD_DIGIT_MIN      = 4'h1;
    localparam logic [3:0]  WD_DIGIT_MAX      = 4'ha;

    // Interval in milliseconds
    localparam int          WD_MS_BITS   = 14;
    localparam logic [13:0] MULT_1S_MS   = 14'h03e8;
    localparam logic [13:0] MULT_100MS_MS = 14'h0064;
    localparam logic [13:0] MULT_10MS_MS = 14'h000a;
    localparam logic [13:0] MULT_1MS_MS  = 14'h0001;

    // Status register fields
    localparam int          ST_VCC_UV_BIT   = 0;
    localparam int          ST_BAT_OV_BIT   = 1;
    localparam int          ST_WD_TO_BIT    = 2;
    localparam int          ST_SPI_ERR_BIT  = 3;
    localparam int          ST_ANY_BIT      = 7;
    localparam logic [6:0]  ST_EXIST_MASK   = 7'h0f;
    localparam logic [6:0]  STATUS_RESET    = 7'h00;

    // Time base: one millisecond tick
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          TICK_PERIOD_NS  = 1000000;
    localparam int          TICK_CYCLES     = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int          RESET_PULSE_MS  = 10;

    // Operating states
    typedef enum logic [2:0] {
        PS_SLEEP    = 3'b001,
        PS_NORMAL   = 3'b010,
        PS_SHUTDOWN = 3'b100
    } power_state_e;

endpackage

// [verilog/spi_word_port.sv]
`timescale 1ns/1ps
// 16-bit serial slave sampled on clk_sys, mode 0
module spi_word_port #(
    parameter int WORD_BITS = supervisor_pkg::SPI_WORD_BITS
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Serial pins
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_mosi,
    output logic                       spi_miso,
    // Word side
    input  wire logic [WORD_BITS-1:0]  tx_word,
    output logic [WORD_BITS-1:0]       rx_word,
    output logic                       frame_ok,
    output logic                       frame_bad
);

    logic                                       sclk_q;
    logic                                       cs_n_q;
    logic [WORD_BITS-1:0]                       rx_q;
    logic [WORD_BITS-1:0]                       tx_q;
    logic [supervisor_pkg::SPI_CNT_BITS-1:0]    cnt_q;
    logic                                       ok_q;
    logic                                       bad_q;
    logic                                       miso_q;

    // Edge decode
    wire rise_w     = spi_sclk & ~sclk_q & ~spi_cs_n;
    wire fall_w     = ~spi_sclk & sclk_q & ~spi_cs_n;
    wire start_w    = ~spi_cs_n & cs_n_q;
    wire end_w      = spi_cs_n & ~cs_n_q;
    wire full_w     = (cnt_q == supervisor_pkg::SPI_CNT_BITS'(WORD_BITS));

    // Pin history
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= spi_sclk;
            cs_n_q <= spi_cs_n;
        end
    end

    // Receive shifter and bit count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_q  <= '0;
            cnt_q <= '0;
        end else if (start_w) begin
            cnt_q <= '0;
        end else if (rise_w) begin
            rx_q  <= {rx_q[WORD_BITS-2:0], spi_mosi};
            cnt_q <= (cnt_q == '1) ? cnt_q : cnt_q + 1'b1; // Saturate so long frames stay bad
        end
    end

    // Transmit shifter, MSB first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_q   <= '0;
            miso_q <= 1'b0;
        end else if (start_w) begin
            tx_q   <= {tx_word[WORD_BITS-2:0], 1'b0};
            miso_q <= tx_word[WORD_BITS-1];
        end else if (fall_w) begin
            tx_q   <= {tx_q[WORD_BITS-2:0], 1'b0};
            miso_q <= tx_q[WORD_BITS-1];
        end
    end

    // Frame end: exactly WORD_BITS clocks accepted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ok_q  <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            ok_q  <= end_w & full_w;
            bad_q <= end_w & ~full_w;
        end
    end

    assign spi_miso  = miso_q;
    assign rx_word   = rx_q;
    assign frame_ok  = ok_q;
    assign frame_bad = bad_q;

endmodule

// [verilog/supervisor_watchdog_selftest.sv]
`timescale 1ns/1ps
// How it works
// - key low, hold low: sleep, everything off
// - key rising in sleep: wake, power-on reset
// - supply present and key high: normal
// - power-on reset: outputs off, defaults loaded
// - self-test flag is control 1 bit 6
// - self-test: status written freely by host
// - otherwise hardware sets, host only clears
// - self-test cleared: status back to default
// - watchdog reset clears self-test flag
// - refresh reloads interval, restarts count
// - missed refresh pulses host reset low
// - host reset restores watchdog enable, 10 s
// - digit 0 means 1, above 10 means 10
// - multiplier bits, largest set one wins
// - configuration bit 7 enables watchdog
// - control bit 7 write means refresh
// - nonzero control bits give temporary interval
// - every timer load clears control register
// - timeout, undervoltage, overvoltage drive reset low
// - reset held fixed time after cause ends
// - soft reset reinitialises registers, no pin pulse
module supervisor_watchdog_selftest #(
    parameter int TICK_CYCLES    = supervisor_pkg::TICK_CYCLES,
    parameter int RESET_PULSE_MS = supervisor_pkg::RESET_PULSE_MS
) (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // Power and supervision inputs
    input  wire logic   key_switch_input,
    input  wire logic   supply_present,
    input  wire logic   vcc_undervoltage,
    input  wire logic   battery_supply_overvoltage,
    // Serial host port
    input  wire logic   spi_cs_n,
    input  wire logic   spi_sclk,
    input  wire logic   spi_mosi,
    output logic        spi_miso,
    // Open-drain host reset
    input  wire logic   host_reset_in,
    output logic        host_reset_out_n,
    output logic        host_reset_oe_n,
    // Block controls
    output logic        outputs_enable,
    output logic        current_sinks_enable,
    output logic        supplies_enable,
    output logic        open_load_detect_en,
    output logic        self_test_active
);

    localparam int TICK_BITS  = $clog2(TICK_CYCLES + 1);
    localparam int PULSE_BITS = $clog2(RESET_PULSE_MS + 1);
    localparam int MS_BITS    = supervisor_pkg::WD_MS_BITS;

    // Interval decode: decimal digit times multiplier in ms
    function automatic logic [MS_BITS-1:0] interval_ms(input logic [7:0] code);
        logic [3:0]         digit;
        logic [MS_BITS-1:0] mult;
        logic [2*MS_BITS-1:0] prod;
        digit = code[supervisor_pkg::WD_DIGIT_MSB:0];
        mult  = supervisor_pkg::MULT_1MS_MS;
        prod  = '0;
        if (digit < supervisor_pkg::WD_DIGIT_MIN) begin
            digit = supervisor_pkg::WD_DIGIT_MIN;
        end else if (digit > supervisor_pkg::WD_DIGIT_MAX) begin
            digit = supervisor_pkg::WD_DIGIT_MAX;
        end
        if (code[supervisor_pkg::WD_MULT_1S_BIT]) begin
            mult = supervisor_pkg::MULT_1S_MS;
        end else if (code[supervisor_pkg::WD_MULT_100MS_BIT]) begin
            mult = supervisor_pkg::MULT_100MS_MS;
        end else if (code[supervisor_pkg::WD_MULT_10MS_BIT]) begin
            mult = supervisor_pkg::MULT_10MS_MS;
        end
        prod = {{MS_BITS{1'b0}}, mult} * {{(2*MS_BITS-4){1'b0}}, digit};
        return prod[MS_BITS-1:0];
    endfunction

    // Serial port
    logic [15:0] rx_word;
    logic        frame_ok;
    logic        frame_bad;
    logic [15:0] resp_q;
    logic [15:0] resp_d;

    spi_word_port #(
        .WORD_BITS (supervisor_pkg::SPI_WORD_BITS)
    ) u_spi (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .spi_cs_n  (spi_cs_n),
        .spi_sclk  (spi_sclk),
        .spi_mosi  (spi_mosi),
        .spi_miso  (spi_miso),
        .tx_word   (resp_q),
        .rx_word   (rx_word),
        .frame_ok  (frame_ok),
        .frame_bad (frame_bad)
    );

    // State and registers
    supervisor_pkg::power_state_e state_q;
    supervisor_pkg::power_state_e state_d;
    logic                   por_q;
    logic                   soft_rst_q;
    logic [7:0]             ctrl1_q;
    logic [7:0]             wd_cfg_q;
    logic [7:0]             wd_ctrl_q;
    logic [6:0]             status_q;
    logic [6:0]             status_d;
    logic                   self_test_prev_q;
    logic [TICK_BITS-1:0]   tick_cnt_q;
    logic                   tick_q;
    logic [MS_BITS-1:0]     wd_cnt_q;
    logic                   wd_run_prev_q;
    logic                   wd_timeout_q;
    logic                   hreset_q;
    logic [PULSE_BITS-1:0]  pulse_cnt_q;
    logic                   outputs_enable_q;
    logic                   sinks_enable_q;
    logic                   supplies_enable_q;
    logic                   open_load_en_q;

    // Frame decode
    wire [3:0] cmd_w       = rx_word[supervisor_pkg::CMD_MSB:supervisor_pkg::CMD_LSB];
    wire [3:0] addr_w      = rx_word[supervisor_pkg::ADDR_MSB:supervisor_pkg::ADDR_LSB];
    wire [7:0] wdata_w     = rx_word[supervisor_pkg::DATA_MSB:0];
    wire       is_write_w  = frame_ok & (cmd_w == supervisor_pkg::CMD_WRITE);
    wire       is_read_w   = frame_ok & (cmd_w == supervisor_pkg::CMD_READ);
    wire       is_check_w  = frame_ok & (cmd_w == supervisor_pkg::CMD_CHECK);
    wire       addr_ok_w   = (addr_w == supervisor_pkg::ADDR_CTRL1) | (addr_w == supervisor_pkg::ADDR_WD_CFG)
                           | (addr_w == supervisor_pkg::ADDR_WD_CTRL) | (addr_w == supervisor_pkg::ADDR_STATUS);
    wire       wr_ctrl1_w  = is_write_w & (addr_w == supervisor_pkg::ADDR_CTRL1);
    wire       wr_cfg_w    = is_write_w & (addr_w == supervisor_pkg::ADDR_WD_CFG);
    wire       wr_ctrl_w   = is_write_w & (addr_w == supervisor_pkg::ADDR_WD_CTRL);
    wire       wr_stat_w   = is_write_w & (addr_w == supervisor_pkg::ADDR_STATUS);
    wire       spi_err_w   = frame_bad | (frame_ok & ~is_check_w & ~((is_write_w | is_read_w) & addr_ok_w));

    // Reset sources
    wire self_test_w   = ctrl1_q[supervisor_pkg::CTRL1_SELF_TEST_BIT];
    wire regs_init_w   = por_q | soft_rst_q;
    wire st_exit_w     = self_test_prev_q & ~self_test_w;
    wire hreset_cause_w = wd_timeout_q | vcc_undervoltage | battery_supply_overvoltage | por_q;
    wire in_sleep_w    = (state_q == supervisor_pkg::PS_SLEEP);
    wire in_normal_w   = (state_q == supervisor_pkg::PS_NORMAL);

    // Watchdog load and interval selection
    wire wd_run_w      = wd_cfg_q[supervisor_pkg::WD_ENABLE_BIT] & ~hreset_q & ~in_sleep_w;
    wire refresh_w     = wr_ctrl_w & wdata_w[supervisor_pkg::WD_ENABLE_BIT];
    wire wd_load_w     = wd_run_w & (refresh_w | ~wd_run_prev_q);
    wire wr_temp_w     = wr_ctrl_w & (wdata_w[supervisor_pkg::WD_TEMP_MSB:0] != '0);
    wire ctrl_temp_w   = (wd_ctrl_q[supervisor_pkg::WD_TEMP_MSB:0] != '0);
    wire [7:0] load_code_w = wr_temp_w   ? wdata_w :
                             ctrl_temp_w ? wd_ctrl_q : wd_cfg_q;
    wire [MS_BITS-1:0] load_ms_w = interval_ms(load_code_w);
    wire wd_expire_w   = wd_run_w & ~wd_load_w & tick_q & (wd_cnt_q == MS_BITS'(1));

    // Power state transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            supervisor_pkg::PS_SLEEP: begin
                if (key_switch_input & supply_present) begin
                    state_d = supervisor_pkg::PS_NORMAL;
                end
            end
            supervisor_pkg::PS_NORMAL: begin
                if (~key_switch_input & ~ctrl1_q[supervisor_pkg::CTRL1_POWER_HOLD_BIT]) begin
                    state_d = supervisor_pkg::PS_SLEEP;
                end else if (~key_switch_input) begin
                    state_d = supervisor_pkg::PS_SHUTDOWN;
                end
            end
            supervisor_pkg::PS_SHUTDOWN: begin
                if (key_switch_input & supply_present) begin
                    state_d = supervisor_pkg::PS_NORMAL;
                end else if (~ctrl1_q[supervisor_pkg::CTRL1_POWER_HOLD_BIT]) begin
                    state_d = supervisor_pkg::PS_SLEEP;
                end
            end
            default: begin
                state_d = supervisor_pkg::PS_SLEEP;
            end
        endcase
    end

    // State register and wake-up reset pulse
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= supervisor_pkg::PS_SLEEP;
            por_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            por_q   <= in_sleep_w & (state_d == supervisor_pkg::PS_NORMAL);
        end
    end

    // Control register 1; soft reset bit self-clears through the reinit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl1_q    <= supervisor_pkg::CTRL1_RESET;
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_ctrl1_w & wdata_w[supervisor_pkg::CTRL1_SOFT_RESET_BIT];
            if (regs_init_w) begin
                ctrl1_q <= supervisor_pkg::CTRL1_RESET;
            end else if (wr_ctrl1_w) begin
                ctrl1_q <= wdata_w;
            end
            if (hreset_q) begin
                ctrl1_q[supervisor_pkg::CTRL1_SELF_TEST_BIT] <= 1'b0;
            end
        end
    end

    // Watchdog configuration, defaults after any host reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_cfg_q <= supervisor_pkg::WD_CFG_RESET;
        end else if (regs_init_w | hreset_q) begin
            wd_cfg_q <= supervisor_pkg::WD_CFG_RESET;
        end else if (wr_cfg_w) begin
            wd_cfg_q <= wdata_w;
        end
    end

    // Watchdog control: temporary interval, cleared on every load
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_ctrl_q <= supervisor_pkg::WD_CTRL_RESET;
        end else if (regs_init_w | wd_load_w) begin
            wd_ctrl_q <= supervisor_pkg::WD_CTRL_RESET;
        end else if (wr_ctrl_w) begin
            wd_ctrl_q <= wdata_w;
        end
    end

    // Status next value: self-test owns it, else set-only from hardware
    always_comb begin
        status_d = status_q;
        if (regs_init_w | st_exit_w) begin
            status_d = supervisor_pkg::STATUS_RESET;
        end else if (self_test_w) begin
            if (wr_stat_w) begin
                status_d = wdata_w[6:0] & supervisor_pkg::ST_EXIST_MASK;
            end
        end else begin
            if (wr_stat_w) begin
                status_d = status_q & wdata_w[6:0];
            end
            status_d[supervisor_pkg::ST_VCC_UV_BIT]  = status_d[supervisor_pkg::ST_VCC_UV_BIT] | vcc_undervoltage;
            status_d[supervisor_pkg::ST_BAT_OV_BIT]  = status_d[supervisor_pkg::ST_BAT_OV_BIT]
                                                     | battery_supply_overvoltage;
            status_d[supervisor_pkg::ST_WD_TO_BIT]   = status_d[supervisor_pkg::ST_WD_TO_BIT] | wd_timeout_q;
            status_d[supervisor_pkg::ST_SPI_ERR_BIT] = status_d[supervisor_pkg::ST_SPI_ERR_BIT] | spi_err_w;
        end
    end

    // Status register and self-test edge tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_q         <= supervisor_pkg::STATUS_RESET;
            self_test_prev_q <= 1'b0;
        end else begin
            status_q         <= status_d;
            self_test_prev_q <= self_test_w;
        end
    end

    // Millisecond time base, realigned on each load
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (wd_load_w | (tick_cnt_q == TICK_BITS'(TICK_CYCLES - 1))) begin
            tick_cnt_q <= '0;
            tick_q     <= ~wd_load_w;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // Watchdog down-counter in milliseconds
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_cnt_q      <= '0;
            wd_run_prev_q <= 1'b0;
            wd_timeout_q  <= 1'b0;
        end else begin
            wd_run_prev_q <= wd_run_w;
            wd_timeout_q  <= wd_expire_w;
            if (wd_load_w) begin
                wd_cnt_q <= load_ms_w;
            end else if (~wd_run_w) begin
                wd_cnt_q <= '0;
            end else if (tick_q & (wd_cnt_q != '0)) begin
                wd_cnt_q <= wd_cnt_q - 1'b1;
            end
        end
    end

    // Host reset: low while any cause, then for a fixed pulse time
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreset_q    <= 1'b1;
            pulse_cnt_q <= '0;
        end else if (hreset_cause_w) begin
            hreset_q    <= 1'b1;
            pulse_cnt_q <= '0;
        end else if (hreset_q & tick_q) begin
            if (pulse_cnt_q == PULSE_BITS'(RESET_PULSE_MS - 1)) begin
                hreset_q <= 1'b0;
            end else begin
                pulse_cnt_q <= pulse_cnt_q + 1'b1;
            end
        end
    end

    // Response for the next frame
    always_comb begin
        resp_d = resp_q;
        if (is_check_w) begin
            resp_d = {supervisor_pkg::CHECK_ECHO_HEAD, rx_word[supervisor_pkg::ECHO_MSB:0]};
        end else if (spi_err_w) begin
            resp_d = '0;
        end else if (frame_ok) begin
            case (addr_w)
                supervisor_pkg::ADDR_CTRL1:   resp_d = {cmd_w, addr_w, ctrl1_q};
                supervisor_pkg::ADDR_WD_CFG:  resp_d = {cmd_w, addr_w, wd_cfg_q};
                supervisor_pkg::ADDR_WD_CTRL: resp_d = {cmd_w, addr_w, wd_ctrl_q};
                supervisor_pkg::ADDR_STATUS:  resp_d = {cmd_w, addr_w, (|status_q), status_q};
                default:                      resp_d = '0;
            endcase
        end
    end

    // Response register and block outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_q            <= '0;
            outputs_enable_q  <= 1'b0;
            sinks_enable_q    <= 1'b0;
            supplies_enable_q <= 1'b0;
            open_load_en_q    <= 1'b0;
        end else begin
            resp_q            <= resp_d;
            outputs_enable_q  <= in_normal_w & ~hreset_q & host_reset_in & ~regs_init_w;
            sinks_enable_q    <= ~in_sleep_w;
            supplies_enable_q <= ~in_sleep_w;
            open_load_en_q    <= ~in_sleep_w;
        end
    end

    // Open-drain: output data is always low, enable active low
    assign host_reset_out_n     = 1'b0;
    assign host_reset_oe_n      = ~hreset_q;
    assign outputs_enable       = outputs_enable_q;
    assign current_sinks_enable = sinks_enable_q;
    assign supplies_enable      = supplies_enable_q;
    assign open_load_detect_en  = open_load_en_q;
    assign self_test_active     = self_test_prev_q;

endmodule

// [tb/supervisor_watchdog_selftest_asserts.sv]
`timescale 1ns/1ps
module supervisor_watchdog_selftest_asserts #(parameter int TICK_CYCLES = 10, parameter int RESET_PULSE_MS = 2) (
    // Watched ports
    input wire logic clk_sys, rst, key_switch_input, supply_present, vcc_undervoltage, battery_supply_overvoltage,
    input wire logic host_reset_oe_n, outputs_enable, supplies_enable, open_load_detect_en, self_test_active
);
    int unsigned low_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Cycles with the reset wire held low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) low_q <= 0;
        else low_q <= host_reset_oe_n ? 0 : low_q + 1;
    end
    // Power states, reset wire and self-test flag
    sleep_off_a: assert property (
        !key_switch_input [*4] |-> !outputs_enable) else $error("output on while asleep");
    wake_por_a: assert property (
        $rose(key_switch_input) && !supplies_enable |-> ##[1:4] !host_reset_oe_n) else $error("no wake reset");
    normal_on_a: assert property (
        (key_switch_input && supply_present) [*4] |-> supplies_enable) else $error("supplies off");
    por_default_a: assert property (
        $rose(host_reset_oe_n) |-> open_load_detect_en) else $error("open load off");
    uv_reset_a: assert property (
        vcc_undervoltage |-> ##[1:2] !host_reset_oe_n) else $error("no undervoltage reset");
    ov_reset_a: assert property (
        battery_supply_overvoltage |-> ##[1:2] !host_reset_oe_n) else $error("no overvoltage reset");
    pulse_len_a: assert property (
        $rose(host_reset_oe_n) |-> low_q >= (RESET_PULSE_MS - 1) * TICK_CYCLES) else $error("reset too short");
    test_clear_a: assert property (
        !host_reset_oe_n [*3] |-> !self_test_active) else $error("self-test kept in reset");
endmodule

// [tb/host_mcu_model.sv]
`timescale 1ns/1ps
// Host: serial master and pull-up on the reset wire
module host_mcu_model (
    input  wire logic clk_sys, spi_miso, host_reset_oe_n,
    output logic      spi_cs_n = 1'b1, spi_sclk = 1'b0, spi_mosi = 1'b0,
    output wire logic host_reset_in
);
    assign host_reset_in = host_reset_oe_n; // Pulled up unless sunk
    // One frame, MSB first, three cycles per clock level
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi <= w[i];
            repeat (3) @(posedge clk_sys);
            spi_sclk <= 1'b1;
            r[i] = spi_miso;
            repeat (3) @(posedge clk_sys);
            spi_sclk <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~w[0];
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// [tb/supervisor_watchdog_selftest_bench.sv]
`timescale 1ns/1ps
module supervisor_watchdog_selftest_bench;
    localparam logic [3:0] C1 = supervisor_pkg::ADDR_CTRL1, CF = supervisor_pkg::ADDR_WD_CFG;
    localparam logic [3:0] CT = supervisor_pkg::ADDR_WD_CTRL, ST = supervisor_pkg::ADDR_STATUS;
    localparam logic [7:0] DEF = supervisor_pkg::WD_CFG_RESET;
    logic clk_sys = 1'b0, rst = 1'b1, key_switch_input = 1'b1, supply_present = 1'b1, vcc_undervoltage = 1'b0;
    logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, host_reset_in, host_reset_oe_n, open_load_detect_en;
    logic self_test_active, outputs_enable, current_sinks_enable, supplies_enable;
    logic [7:0] cfgs [4];
    logic [15:0] r;
    int error_cnt = 0, checks = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    supervisor_watchdog_selftest #(.TICK_CYCLES(10), .RESET_PULSE_MS(2)) supervisor_watchdog_selftest_i (.*,
        .battery_supply_overvoltage(vcc_undervoltage), .host_reset_out_n());
    host_mcu_model host_mcu_model_i (.*);
    // Cycle ceiling against hangs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Register access; a read answer arrives in the following frame
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_mcu_model_i.xfer({supervisor_pkg::CMD_WRITE, a, d}, r);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        host_mcu_model_i.xfer({supervisor_pkg::CMD_READ, a, 8'h00}, r);
        host_mcu_model_i.xfer(16'h0000, r);
        check(r, {supervisor_pkg::CMD_READ, a, e});
    endtask
    task automatic rel();
        repeat (3) @(posedge clk_sys);
        while (host_reset_oe_n !== 1'b1) @(posedge clk_sys);
    endtask
    // Milliseconds until the watchdog sinks the reset wire
    task automatic to_ms(input int ms);
        int n = 0;
        while (host_reset_oe_n === 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        check(16'(n / 10 >= ms - 1 && n / 10 <= ms + 1), 16'h1);
        rel();
    endtask
    function automatic int ivl(input logic [7:0] c);
        int d = c[3:0] == 4'h0 ? 1 : c[3:0] > 4'ha ? 10 : int'(c[3:0]);
        return d * (c[6] ? 1000 : c[5] ? 100 : c[4] ? 10 : 1);
    endfunction
    initial begin
        void'($urandom(32'h128ee970));
        cfgs = '{8'h10 | 8'($urandom % 16), 8'h31, 8'h40, 8'h0c};
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rel();
        rd(CF, DEF);
        check(16'(open_load_detect_en), 16'h1);
        wr(C1, 8'h40);
        check(16'(self_test_active), 16'h1);
        wr(ST, 8'h0f);
        rd(ST, 8'h8f);
        wr(C1, 8'h00);
        rd(ST, 8'h00);
        vcc_undervoltage <= 1'b1;
        repeat (5) @(posedge clk_sys);
        vcc_undervoltage <= 1'b0;
        rel();
        rd(ST, 8'h83);
        wr(ST, 8'h0c);
        rd(ST, 8'h00);
        $display("status tests done");
        foreach (cfgs[i]) begin
            wr(CF, cfgs[i]);
            repeat (300) @(posedge clk_sys);
            check(16'(host_reset_oe_n), 16'h1);
            wr(CF, cfgs[i] | 8'h80);
            to_ms(ivl(cfgs[i]));
        end
        wr(CF, 8'h85);
        wr(C1, 8'h40);
        wr(CT, 8'h94);
        rd(CT, 8'h00);
        check(16'(host_reset_oe_n), 16'h1);
        wr(CT, 8'h80);
        to_ms(5);
        check(16'(self_test_active), 16'h0);
        rd(CF, DEF);
        wr(CF, 8'h05);
        wr(C1, 8'h80);
        check(16'(host_reset_oe_n), 16'h1);
        rd(CF, DEF);
        $display("watchdog tests done");
        wr(CF, 8'h05);
        wr(C1, 8'h01);
        key_switch_input <= 1'b0;
        repeat (40) @(posedge clk_sys);
        check(16'({outputs_enable, supplies_enable}), 16'h1);
        wr(C1, 8'h00);
        repeat (4) @(posedge clk_sys);
        check(16'({outputs_enable, current_sinks_enable}), 16'h0);
        key_switch_input <= 1'b1;
        rel();
        rd(CF, DEF);
        $display("sleep test done");
        end_of_test();
    end
endmodule
bind supervisor_watchdog_selftest supervisor_watchdog_selftest_asserts #(.TICK_CYCLES(TICK_CYCLES),
    .RESET_PULSE_MS(RESET_PULSE_MS)) asserts_i (.*);
